// file: hdl/axis_wrap_clamp.sv
`timescale 1ns/10ps
module axis_wrap_clamp
  import tex_clamp_pkg::*;
(
  input  wire tex_clamp_pkg::coord_t     coordIn,
  input  wire tex_clamp_pkg::wrap_mode_t mode,
  input  wire tex_clamp_pkg::log2_t      log2Size,
  input  wire tex_clamp_pkg::filter_t    filter,
  input  wire logic                      edgeOk,
  output tex_clamp_pkg::coord_t          coordOut,
  output logic                           limited
);

  // lower edge-clamp limit from image size and filter
  function automatic coord_t edgeMin(input log2_t k, input filter_t f);
    coord_t unit;
    unit = COORD_ONE >>> ({1'b0, k} + 5'h01);
    if (f == FOUR_TAP_FILTER) begin
      if (k < 4'h2) begin
        edgeMin = COORD_HALF;
      end else begin
        edgeMin = (unit <<< 1) + unit;
      end
    end else begin
      edgeMin = unit;
    end
  endfunction : edgeMin

  coord_t lo;
  coord_t hi;

  // limits then wrap or clamp
  always_comb begin
    lo       = COORD_ZERO;
    hi       = COORD_ONE;
    coordOut = coordIn;
    limited  = 1'b0;
    unique case (mode)
      WRAP_REPEAT: begin
        coordOut = coordIn & FRAC_MASK;
      end
      WRAP_CLAMP: begin
        lo = COORD_ZERO;
        hi = COORD_ONE;
      end
      EDGE_CLAMP_MODE: begin
        if (edgeOk) begin
          lo = edgeMin(log2Size, filter);
          hi = COORD_ONE - lo;
        end
      end
    endcase
    if (mode != WRAP_REPEAT) begin
      if (coordIn < lo) begin
        coordOut = lo;
        limited  = 1'b1;
      end else if (coordIn > hi) begin
        coordOut = hi;
        limited  = 1'b1;
      end
    end
  end

endmodule : axis_wrap_clamp

// file: hdl/tex_clamp_pkg.sv
package tex_clamp_pkg;

  // coordinate format: signed fixed point, FRAC_W fraction bits
  localparam int COORD_W = 24;
  localparam int FRAC_W  = 16;
  localparam int LOG2_W  = 4;
  localparam int AXES    = 3;

  typedef logic signed [COORD_W-1:0] coord_t;
  typedef logic [LOG2_W-1:0]         log2_t;

  localparam coord_t COORD_ZERO = 24'h000000;
  localparam coord_t COORD_ONE  = 24'h010000;
  localparam coord_t COORD_HALF = 24'h008000;
  localparam coord_t FRAC_MASK  = 24'h00FFFF;

  // wrap selection codes seen on the register bus
  localparam logic [15:0] CODE_EDGE   = 16'h812F;
  localparam logic [15:0] CODE_CLAMP  = 16'h0001; // arbitrary value
  localparam logic [15:0] CODE_REPEAT = 16'h0002; // arbitrary value

  typedef enum logic [1:0] {
    WRAP_REPEAT,
    WRAP_CLAMP,
    EDGE_CLAMP_MODE
  } wrap_mode_t;

  typedef enum logic [1:0] {
    FILT_NEAREST,
    FILT_LINEAR,
    FOUR_TAP_FILTER
  } filter_t;

  typedef enum logic [1:0] {
    DIM_1D,
    DIM_2D,
    DIM_3D,
    DIM_OTHER
  } dim_t;

  // register byte addresses
  localparam logic [7:0] ADDR_WRAP_S = 8'h00;
  localparam logic [7:0] ADDR_WRAP_T = 8'h04;
  localparam logic [7:0] ADDR_WRAP_R = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_SIZE   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_COUNT  = 8'h18;

  // field positions
  localparam int CFG_FILT_LSB  = 0;
  localparam int CFG_DIM_LSB   = 2;
  localparam int SIZE_S_LSB    = 0;
  localparam int SIZE_T_LSB    = 4;
  localparam int SIZE_R_LSB    = 8;
  localparam int STAT_BAD_BIT  = 0;
  localparam int STAT_FALL_BIT = 1;
  localparam int STAT_HIT_LSB  = 4;

  // reset values
  localparam filter_t    RST_FILTER = FILT_LINEAR;
  localparam dim_t       RST_DIM    = DIM_2D;
  localparam log2_t      RST_LOG2   = 4'h0;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic   valid;
    coord_t s;
    coord_t t;
    coord_t r;
  } coord_bus_t;

endpackage : tex_clamp_pkg

// file: hdl/texture_coord_edge_clamp.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module texture_coord_edge_clamp
  import tex_clamp_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire tex_clamp_pkg::apb_req_t   apbReq,
  output tex_clamp_pkg::apb_rsp_t        apbRsp,
  input  wire tex_clamp_pkg::coord_bus_t coordIn,
  output tex_clamp_pkg::coord_bus_t      coordOut,
  output logic [2:0]                     coordLimited
);

  import tex_clamp_pkg::*;

  typedef enum logic [2:0] {
    SEL_WRAP_S,
    SEL_WRAP_T,
    SEL_WRAP_R,
    SEL_CONFIG,
    SEL_SIZE,
    SEL_STATUS,
    SEL_COUNT,
    SEL_NONE
  } reg_sel_t;

  typedef struct packed {
    logic       ok;
    wrap_mode_t mode;
  } code_dec_t;

  typedef struct packed {
    apb_rsp_t   rsp;
    wrap_mode_t wrapS;
    wrap_mode_t wrapT;
    wrap_mode_t wrapR;
    filter_t    filter;
    dim_t       dim;
    log2_t      log2S;
    log2_t      log2T;
    log2_t      log2R;
    logic       badCode;
    logic [2:0] hitSticky;
    logic [15:0] count;
    coord_bus_t out;
    logic [2:0] limited;
  } state_t;

  state_t state;
  state_t next_state;

  // register select from a byte address
  function automatic reg_sel_t regIndex(input logic [7:0] addr);
    unique case (addr)
      ADDR_WRAP_S: regIndex = SEL_WRAP_S;
      ADDR_WRAP_T: regIndex = SEL_WRAP_T;
      ADDR_WRAP_R: regIndex = SEL_WRAP_R;
      ADDR_CONFIG: regIndex = SEL_CONFIG;
      ADDR_SIZE:   regIndex = SEL_SIZE;
      ADDR_STATUS: regIndex = SEL_STATUS;
      ADDR_COUNT:  regIndex = SEL_COUNT;
      default:     regIndex = SEL_NONE;
    endcase
  endfunction : regIndex

  // bus code to wrap mode; anything else is refused
  function automatic code_dec_t codeToMode(input logic [31:0] data);
    codeToMode.ok   = 1'b1;
    codeToMode.mode = WRAP_REPEAT;
    if (data[31:16] != 16'h0000) begin
      codeToMode.ok = 1'b0;
    end else if (data[15:0] == CODE_EDGE) begin
      codeToMode.mode = EDGE_CLAMP_MODE;
    end else if (data[15:0] == CODE_CLAMP) begin
      codeToMode.mode = WRAP_CLAMP;
    end else if (data[15:0] == CODE_REPEAT) begin
      codeToMode.mode = WRAP_REPEAT;
    end else begin
      codeToMode.ok = 1'b0;
    end
  endfunction : codeToMode

  // wrap mode back to its bus code
  function automatic logic [31:0] modeToCode(input wrap_mode_t m);
    modeToCode = 32'h00000000;
    unique case (m)
      WRAP_REPEAT:     modeToCode = {16'h0000, CODE_REPEAT};
      WRAP_CLAMP:      modeToCode = {16'h0000, CODE_CLAMP};
      EDGE_CLAMP_MODE: modeToCode = {16'h0000, CODE_EDGE};
    endcase
  endfunction : modeToCode

  // edge clamp honoured only for one to three dimensions
  logic edgeOk;
  logic fallback;

  assign edgeOk   = (state.dim != DIM_OTHER);
  assign fallback = !edgeOk && ((state.wrapS == EDGE_CLAMP_MODE) ||
                                (state.wrapT == EDGE_CLAMP_MODE) ||
                                (state.wrapR == EDGE_CLAMP_MODE));

  // per-axis datapath
  coord_t     clampS;
  coord_t     clampT;
  coord_t     clampR;
  logic [2:0] limNow;

  axis_wrap_clamp axisS (
    .coordIn  (coordIn.s),
    .mode     (state.wrapS),
    .log2Size (state.log2S),
    .filter   (state.filter),
    .edgeOk   (edgeOk),
    .coordOut (clampS),
    .limited  (limNow[0])
  );

  axis_wrap_clamp axisT (
    .coordIn  (coordIn.t),
    .mode     (state.wrapT),
    .log2Size (state.log2T),
    .filter   (state.filter),
    .edgeOk   (edgeOk),
    .coordOut (clampT),
    .limited  (limNow[1])
  );

  axis_wrap_clamp axisR (
    .coordIn  (coordIn.r),
    .mode     (state.wrapR),
    .log2Size (state.log2R),
    .filter   (state.filter),
    .edgeOk   (edgeOk),
    .coordOut (clampR),
    .limited  (limNow[2])
  );

  // bus transfer phases
  logic     setupPhase;
  logic     accessDone;
  logic     wrEvent;
  reg_sel_t selSetup;
  reg_sel_t selAccess;

  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessDone = apbReq.psel && apbReq.penable && state.rsp.pready;
  assign wrEvent    = accessDone && apbReq.pwrite;
  assign selSetup   = regIndex(apbReq.paddr);
  assign selAccess  = regIndex(apbReq.paddr);

  // next state
  always_comb begin
    code_dec_t   dec;
    logic [31:0] rd;
    logic [2:0]  hitSet;
    next_state = state;
    dec        = codeToMode(apbReq.pwdata);
    rd         = 32'h00000000;
    hitSet     = 3'h0;

    // no wait state: answer in the first access cycle
    next_state.rsp.pready = setupPhase;
    if (setupPhase) begin
      next_state.rsp.pslverr = (selSetup == SEL_NONE);
      unique case (selSetup)
        SEL_WRAP_S: rd = modeToCode(state.wrapS);
        SEL_WRAP_T: rd = modeToCode(state.wrapT);
        SEL_WRAP_R: rd = modeToCode(state.wrapR);
        SEL_CONFIG: begin
          rd[CFG_FILT_LSB +: 2] = state.filter;
          rd[CFG_DIM_LSB +: 2]  = state.dim;
        end
        SEL_SIZE: begin
          rd[SIZE_S_LSB +: LOG2_W] = state.log2S;
          rd[SIZE_T_LSB +: LOG2_W] = state.log2T;
          rd[SIZE_R_LSB +: LOG2_W] = state.log2R;
        end
        SEL_STATUS: begin
          rd[STAT_BAD_BIT]         = state.badCode;
          rd[STAT_FALL_BIT]        = fallback;
          rd[STAT_HIT_LSB +: AXES] = state.hitSticky;
        end
        SEL_COUNT: rd[15:0] = state.count;
        SEL_NONE:  rd = 32'h00000000;
      endcase
      next_state.rsp.prdata = apbReq.pwrite ? 32'h00000000 : rd;
    end else if (accessDone) begin
      next_state.rsp.prdata  = 32'h00000000;
      next_state.rsp.pslverr = 1'b0;
    end

    // register writes at the completing edge
    if (wrEvent) begin
      unique case (selAccess)
        SEL_WRAP_S: begin
          if (dec.ok) begin
            next_state.wrapS = dec.mode;
          end
        end
        SEL_WRAP_T: begin
          if (dec.ok) begin
            next_state.wrapT = dec.mode;
          end
        end
        SEL_WRAP_R: begin
          if (dec.ok) begin
            next_state.wrapR = dec.mode;
          end
        end
        SEL_CONFIG: begin
          if (apbReq.pwdata[CFG_FILT_LSB +: 2] != 2'h3) begin
            next_state.filter = filter_t'(apbReq.pwdata[CFG_FILT_LSB +: 2]);
          end
          next_state.dim = dim_t'(apbReq.pwdata[CFG_DIM_LSB +: 2]);
        end
        SEL_SIZE: begin
          next_state.log2S = apbReq.pwdata[SIZE_S_LSB +: LOG2_W];
          next_state.log2T = apbReq.pwdata[SIZE_T_LSB +: LOG2_W];
          next_state.log2R = apbReq.pwdata[SIZE_R_LSB +: LOG2_W];
        end
        SEL_STATUS: begin
          if (apbReq.pwdata[STAT_BAD_BIT]) begin
            next_state.badCode = 1'b0;
          end
          next_state.hitSticky = state.hitSticky & ~apbReq.pwdata[STAT_HIT_LSB +: AXES];
        end
        SEL_COUNT: next_state.count = RST_COUNT;
        SEL_NONE:  next_state.count = state.count;
      endcase
    end

    // sticky refusal flag; set wins over clear
    if (wrEvent && !dec.ok && (selAccess == SEL_WRAP_S || selAccess == SEL_WRAP_T ||
                               selAccess == SEL_WRAP_R)) begin
      next_state.badCode = 1'b1;
    end
    if (wrEvent && selAccess == SEL_CONFIG && apbReq.pwdata[CFG_FILT_LSB +: 2] == 2'h3) begin
      next_state.badCode = 1'b1;
    end

    // coordinate stage
    next_state.out.valid = coordIn.valid;
    next_state.limited   = 3'h0;
    if (coordIn.valid) begin
      next_state.out.s   = clampS;
      next_state.out.t   = clampT;
      next_state.out.r   = clampR;
      next_state.limited = limNow;
      hitSet             = limNow;
      next_state.count   = state.count + 16'h0001;
    end
    next_state.hitSticky = next_state.hitSticky | hitSet;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state.rsp       <= '0;
      state.wrapS     <= WRAP_REPEAT;
      state.wrapT     <= WRAP_REPEAT;
      state.wrapR     <= WRAP_REPEAT;
      state.filter    <= RST_FILTER;
      state.dim       <= RST_DIM;
      state.log2S     <= RST_LOG2;
      state.log2T     <= RST_LOG2;
      state.log2R     <= RST_LOG2;
      state.badCode   <= 1'b0;
      state.hitSticky <= 3'h0;
      state.count     <= RST_COUNT;
      state.out       <= '0;
      state.limited   <= 3'h0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state register
  assign apbRsp       = state.rsp;
  assign coordOut     = state.out;
  assign coordLimited = state.limited;

endmodule : texture_coord_edge_clamp

// file: testbench/coord_source.sv
`timescale 1ns/10ps
module coord_source
  import tex_clamp_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  go,
  input  wire tex_clamp_pkg::coord_t val,
  output tex_clamp_pkg::coord_bus_t  coordIn
);
  // one sample per request, lines toggle between samples
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coordIn <= '0;
    end else if (go) begin
      coordIn <= '{1'b1, val, val, val};
    end else begin
      coordIn <= '{1'b0, ~coordIn.s, ~coordIn.t, ~coordIn.r};
    end
  end
endmodule : coord_source

// file: testbench/tex_clamp_chk.sv
`timescale 1ns/10ps
module tex_clamp_chk
  import tex_clamp_pkg::*;
(
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire tex_clamp_pkg::apb_req_t   apbReq,
  input wire tex_clamp_pkg::apb_rsp_t   apbRsp,
  input wire tex_clamp_pkg::coord_bus_t coordIn,
  input wire tex_clamp_pkg::coord_bus_t coordOut,
  input wire logic [2:0]                coordLimited
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // coordinate inside the unit range
  function automatic logic inb(coord_t c);
    return c >= COORD_ZERO && c <= COORD_ONE;
  endfunction : inb
  // bus phases
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_answer;
    apbRsp.pready ##1 !apbRsp.pready;
  endsequence
  property p_wait1; s_setup |=> s_answer; endproperty
  a_wait1: assert property (p_wait1) else $error("ready not one cycle after setup");
  property p_err; apbRsp.pslverr |-> apbRsp.pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_lat; coordIn.valid |=> coordOut.valid; endproperty
  a_lat: assert property (p_lat) else $error("sample lost");
  property p_idle; !coordIn.valid |=> !coordOut.valid; endproperty
  a_idle: assert property (p_idle) else $error("spurious sample");
  property p_range; coordOut.valid |-> inb(coordOut.s) && inb(coordOut.t) && inb(coordOut.r); endproperty
  a_range: assert property (p_range) else $error("coordinate outside unit range");
  property p_lim; coordLimited[0] |-> coordOut.s != $past(coordIn.s); endproperty
  a_lim: assert property (p_lim) else $error("limited flag without change");
  property p_keep;
    coordOut.valid && !coordLimited[0] && $past(coordIn.s) >= COORD_ZERO && $past(coordIn.s) < COORD_ONE
      |-> coordOut.s == $past(coordIn.s);
  endproperty
  a_keep: assert property (p_keep) else $error("in-range coordinate altered");
  property p_limv; coordLimited != 3'b000 |-> coordOut.valid; endproperty
  a_limv: assert property (p_limv) else $error("limited flag without sample");
endmodule : tex_clamp_chk

// file: testbench/texture_coord_edge_clamp_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module texture_coord_edge_clamp_test;
  import tex_clamp_pkg::*;
  typedef struct packed {
    logic [15:0] code;
    logic [3:0]  cfg;
    log2_t       k;
    coord_t      cin;
    coord_t      cout;
    logic        lim;
  } row_t;
  logic        clk_sys;
  logic        rst_n;
  apb_req_t    apbReq;
  apb_rsp_t    apbRsp;
  coord_bus_t  coordIn;
  coord_bus_t  coordOut;
  logic [2:0]  coordLimited;
  logic        go;
  coord_t      val;
  logic [31:0] rd;
  logic        err;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;
  row_t        rows [12];

  texture_coord_edge_clamp dut (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .coordIn(coordIn), .coordOut(coordOut), .coordLimited(coordLimited));
  coord_source feed (.clk_sys(clk_sys), .rst_n(rst_n), .go(go), .val(val), .coordIn(coordIn));

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  // one coordinate through the partner, result checked on all axes
  task automatic sample(input coord_t x, input coord_t e, input logic l);
    @(posedge clk_sys);
    go <= 1'b1;
    val <= x;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("valid", 1'b1, coordOut.valid)
    `CHK("s", e, coordOut.s)
    `CHK("t", e, coordOut.t)
    `CHK("r", e, coordOut.r)
    `CHK("limited", {l, l, l}, coordLimited)
  endtask : sample

  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    go = 1'b0;
    val = '0;
    // mode, config, log2 size, input, expected, limited
    rows = '{'{CODE_REPEAT, 4'h5, 4'h0, 24'h018000, 24'h008000, 1'b0},
             '{CODE_REPEAT, 4'h5, 4'h0, 24'hFFC000, 24'h00C000, 1'b0},
             '{CODE_CLAMP,  4'h5, 4'h0, 24'h018000, 24'h010000, 1'b1},
             '{CODE_CLAMP,  4'h5, 4'h0, 24'hFF0000, 24'h000000, 1'b1},
             '{CODE_EDGE,   4'h5, 4'h2, 24'h000000, 24'h002000, 1'b1},
             '{CODE_EDGE,   4'h4, 4'h3, 24'h020000, 24'h00F000, 1'b1},
             '{CODE_EDGE,   4'h6, 4'h3, 24'h00FF00, 24'h00D000, 1'b1},
             '{CODE_EDGE,   4'h6, 4'h1, 24'h000000, 24'h008000, 1'b1},
             '{CODE_EDGE,   4'h6, 4'h2, 24'h005FFF, 24'h006000, 1'b1},
             '{CODE_EDGE,   4'h1, 4'h0, 24'h000000, 24'h008000, 1'b1},
             '{CODE_EDGE,   4'h9, 4'h4, 24'h008000, 24'h008000, 1'b0},
             '{CODE_EDGE,   4'hD, 4'h2, 24'h018000, 24'h010000, 1'b1}};
    repeat (3) @(posedge clk_sys);
    `CHK("valid in reset", 1'b0, coordOut.valid)
    `CHK("ready in reset", 1'b0, apbRsp.pready)
    rst_n <= 1'b1;
    // every axis starts at repeat
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 8'(4 * a), 32'h0);
      `CHK("wrap reset", 32'(CODE_REPEAT), rd)
    end
    $display("reset values done");
    // table of modes, filters, sizes and dimensions
    foreach (rows[i]) begin
      for (int a = 0; a < 3; a++) apb(1'b1, 8'(4 * a), 32'(rows[i].code));
      apb(1'b1, ADDR_CONFIG, 32'(rows[i].cfg));
      apb(1'b1, ADDR_SIZE, 32'({rows[i].k, rows[i].k, rows[i].k}));
      apb(1'b0, ADDR_WRAP_R, 32'h0);
      `CHK("wrap code", 32'(rows[i].code), rd)
      sample(rows[i].cin, rows[i].cout, rows[i].lim);
      $display("row %0d done", i);
    end
    // illegal code refused, edge on other dimension flagged
    apb(1'b1, ADDR_WRAP_S, 32'h0000_1234);
    apb(1'b0, ADDR_WRAP_S, 32'h0);
    `CHK("wrap kept", 32'(CODE_EDGE), rd)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status", 2'b11, rd[1:0])
    `CHK("hit sticky", 3'b111, rd[6:4])
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    $display("refusals done");
    // sample count, clears, filter refusal, size readback
    apb(1'b0, ADDR_COUNT, 32'h0);
    `CHK("sample count", 32'h0000000C, rd)
    apb(1'b1, ADDR_COUNT, 32'h0);
    `CHK("write rdata", 32'h00000000, rd)
    apb(1'b0, ADDR_COUNT, 32'h0);
    `CHK("count cleared", 32'h00000000, rd)
    apb(1'b1, ADDR_STATUS, 32'h00000071);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status cleared", 32'h00000002, rd)
    apb(1'b1, ADDR_CONFIG, 32'h00000007);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    `CHK("filter kept", 32'h00000005, rd)
    `CHK("mapped err", 1'b0, err)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("bad on filter", 32'h00000001, rd)
    apb(1'b0, ADDR_SIZE, 32'h0);
    `CHK("size", 32'h00000222, rd)
    $display("registers done");
    // reset in mid-run brings back repeat
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("valid mid reset", 1'b0, coordOut.valid)
    `CHK("s mid reset", 24'h000000, coordOut.s)
    `CHK("limited mid reset", 3'h0, coordLimited)
    `CHK("ready mid reset", 1'b0, apbRsp.pready)
    rst_n <= 1'b1;
    apb(1'b0, ADDR_WRAP_T, 32'h0);
    `CHK("wrap after reset", 32'(CODE_REPEAT), rd)
    sample(24'h018000, 24'h008000, 1'b0);
    $display("second reset done");
    wrap_up();
  end
endmodule : texture_coord_edge_clamp_test

bind texture_coord_edge_clamp tex_clamp_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq),
  .apbRsp(apbRsp), .coordIn(coordIn), .coordOut(coordOut), .coordLimited(coordLimited));
